// [logic/pecsr_pkg.sv]
// Package for the error counter and extra status register bank.
// Assumes a classic Wishbone slave with 32-bit data and a byte address.
package pecsr_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  // Register byte addresses, one aligned word each
  localparam logic [ADDR_W-1:0] ERR_CNT_ADDR = 8'h54;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h70;

  // Error counter register layout
  localparam int WIDTH_SEL_BIT = 0;
  localparam int WIDE_LSB = 0;
  localparam int WIDE_W = 16;
  localparam int DISC_LSB = 12;
  localparam int DISC_W = 4;
  localparam int FALSE_LSB = 8;
  localparam int FALSE_W = 4;
  localparam int NARROW_LSB = 0;
  localparam int NARROW_W = 8;

  // Status register layout
  localparam int MISSING_DELIM_BIT = 8;
  localparam int CODE_VIOL_BIT = 7;
  localparam int LINK_DROP_BIT = 5;
  localparam int UNLOCK_BIT = 4;
  localparam int FALSE_CARRIER_BIT = 3;
  localparam int JAM_BIT = 2;
  localparam int FAST_LINK_BIT = 1;
  localparam int SLOW_LINK_BIT = 0;
  localparam int RSVD_HI_LSB = 9;
  localparam int RSVD_HI_MSB = 15;
  localparam int NUM_FLAGS = 6;
  localparam int FLAG_POS [NUM_FLAGS] = '{MISSING_DELIM_BIT, CODE_VIOL_BIT,
    LINK_DROP_BIT, UNLOCK_BIT, FALSE_CARRIER_BIT, JAM_BIT};

  // Reset values
  localparam logic WIDTH_SEL_RST = 1'b0;
  localparam logic [REG_W-1:0] CNT_RST = 16'h0000;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 6'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADDR_W-1:0] adr;
    logic [3:0] sel;
    logic [DATA_W-1:0] dat;
  } pecsr_wb_req_t;

  // Event strobes and live link levels from the transceiver core
  typedef struct packed {
    logic rx_error;
    logic disconnect;
    logic false_error;
    logic missing_delim;
    logic code_violation;
    logic link_drop;
    logic scrambler_unlock;
    logic false_carrier;
    logic jam_forced;
    logic fast_link;
    logic slow_link;
  } pecsr_events_t;

endpackage

// [logic/pecsr_regs.sv]
// Error event counter and extra status register, Wishbone classic slave.
// Assumes event strobes and link levels come from logic on i_mclk.
//
// Function
// R1 - Counter bit 0 is write-only width select: 1 split, 0 wide; resets 0.
// R2 - Wide mode: bits 15:0 count receive-error indications.
// R3 - Reading the counter register clears every counter field.
// R4 - Split mode: bits 15:12 count disconnect events from link instability.
// R5 - Split mode: bits 11:8 count false error events.
// R6 - Split mode: bits 7:0 count receive-error indications.
// R7 - Status bits 15:9 are reserved and read as zero.
// R8 - Status bit 8 latches a frame without delimiter until read or reset.
// R9 - Status bit 7 latches a code violation until the status read.
// R10 - Status bit 5 latches a link disconnect until read.
// R11 - Status bit 4 latches scrambler loss of lock until read.
// R12 - Status bit 3 latches a false carrier until read.
// R13 - Status bit 2 latches a forced jam until read.
// R14 - Status bit 1 shows live that the fast transceiver is up.
// R15 - Status bit 0 shows live that the slow transceiver is up.
// R16 - An event meeting a clearing read is kept for the next read.
// R17 - Each counter field stops at all ones until a read clears it.
`timescale 1ns/1ps

module pecsr_regs (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire pecsr_pkg::pecsr_wb_req_t i_wb,
  input wire pecsr_pkg::pecsr_events_t i_events,
  output logic o_wb_ack,
  output logic [pecsr_pkg::DATA_W-1:0] o_wb_dat
);
  import pecsr_pkg::*;

  logic width_sel;
  logic [REG_W-1:0] count;
  logic [REG_W-1:0] next_count;
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] flag_events;
  logic [REG_W-1:0] status_word;
  logic [DATA_W-1:0] next_rdata;
  logic access;
  logic hit_cnt;
  logic hit_stat;
  logic rd_cnt;
  logic rd_stat;
  logic wr_sel;

  // Bus decode; one access per request, taken in the cycle before ack
  assign access = i_wb.cyc & i_wb.stb & ~o_wb_ack;
  assign hit_cnt = (i_wb.adr == ERR_CNT_ADDR);
  assign hit_stat = (i_wb.adr == STATUS_ADDR);
  assign rd_cnt = access & ~i_wb.we & hit_cnt;
  assign rd_stat = access & ~i_wb.we & hit_stat;
  assign wr_sel = access & i_wb.we & hit_cnt & i_wb.sel[0];

  // Width select; write-only, never reflected in read data
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      width_sel <= WIDTH_SEL_RST;
    end else if (i_clk_en && wr_sel) begin
      width_sel <= i_wb.dat[WIDTH_SEL_BIT]; // [R1]
    end
  end

  // Counter next value. The clear comes first, then the increment, so an
  // event in the clearing cycle survives into the next read.
  always_comb begin
    logic [REG_W-1:0] base;
    base = rd_cnt ? CNT_RST : count; // [R3]
    next_count = base;
    if (!width_sel) begin
      // Wide mode: one count, held at all ones
      if (i_events.rx_error && (base != {REG_W{1'b1}})) begin // [R17]
        next_count = base + 16'h0001; // [R2] [R16]
      end
    end else begin
      // Split mode: three independent fields, each saturating
      if (i_events.disconnect &&
          (base[DISC_LSB +: DISC_W] != {DISC_W{1'b1}})) begin // [R17]
        next_count[DISC_LSB +: DISC_W] =
          base[DISC_LSB +: DISC_W] + 4'h1; // [R4] [R16]
      end
      if (i_events.false_error &&
          (base[FALSE_LSB +: FALSE_W] != {FALSE_W{1'b1}})) begin // [R17]
        next_count[FALSE_LSB +: FALSE_W] =
          base[FALSE_LSB +: FALSE_W] + 4'h1; // [R5] [R16]
      end
      if (i_events.rx_error &&
          (base[NARROW_LSB +: NARROW_W] != {NARROW_W{1'b1}})) begin // [R17]
        next_count[NARROW_LSB +: NARROW_W] =
          base[NARROW_LSB +: NARROW_W] + 8'h01; // [R6] [R16]
      end
    end
  end

  // Counter register; a width change keeps the bits as they stand
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count <= CNT_RST;
    end else if (i_clk_en) begin
      count <= next_count;
    end
  end

  // Flag sources; index i lands on status bit FLAG_POS[i], so index 0 is the frame flag
  assign flag_events = {i_events.jam_forced, i_events.false_carrier,
                        i_events.scrambler_unlock, i_events.link_drop,
                        i_events.code_violation, i_events.missing_delim};

  // Latched-high flags; a set in the reading cycle beats the clear
  generate
    for (genvar g = 0; g < NUM_FLAGS; g++) begin : g_flag
      always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          flags[g] <= FLAGS_RST[g];
        end else if (i_clk_en) begin
          // [R8] [R9] [R10] [R11] [R12] [R13] [R16]
          flags[g] <= flag_events[g] | (flags[g] & ~rd_stat);
        end
      end
    end
  endgenerate

  // Status word assembly; reserved bits stay zero
  always_comb begin
    status_word = '0; // [R7]
    for (int i = 0; i < NUM_FLAGS; i++) begin
      status_word[FLAG_POS[i]] = flags[i];
    end
    status_word[FAST_LINK_BIT] = i_events.fast_link; // [R14]
    status_word[SLOW_LINK_BIT] = i_events.slow_link; // [R15]
  end

  // Read mux; unmapped addresses and writes read as zero
  always_comb begin
    next_rdata = RDATA_RST;
    if (rd_cnt) begin
      next_rdata[REG_W-1:0] = count;
    end else if (rd_stat) begin
      next_rdata[REG_W-1:0] = status_word;
    end
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
    end else if (i_clk_en) begin
      o_wb_ack <= access;
    end
  end

  // Read data registered alongside ack, so it samples pre-clear values
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wb_dat <= RDATA_RST;
    end else if (i_clk_en) begin
      o_wb_dat <= next_rdata;
    end
  end

  // Checks, sampled on the bus clock and quiet during reset
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  a_width_sel_write: assert property ( // [R1]
    i_clk_en && wr_sel |=> width_sel == $past(i_wb.dat[WIDTH_SEL_BIT]))
    else $error("width select did not take the written bit");

  a_width_sel_hold: assert property ( // [R1]
    !(i_clk_en && wr_sel) |=> $stable(width_sel))
    else $error("width select changed without a write");

  a_wide_count_inc: assert property ( // [R2]
    i_clk_en && !width_sel && i_events.rx_error && !rd_cnt
      && count != 16'hffff
    |=> count == $past(count) + 16'h0001)
    else $error("wide count missed a receive error");

  a_read_clears_cnt: assert property ( // [R3]
    i_clk_en && rd_cnt && !i_events.rx_error && !i_events.disconnect
      && !i_events.false_error
    |=> count == 16'h0000 && o_wb_ack)
    else $error("counter read did not clear the fields");

  a_disc_field_inc: assert property ( // [R4]
    i_clk_en && width_sel && i_events.disconnect && !rd_cnt
      && count[DISC_LSB +: DISC_W] != 4'hf
    |=> count[DISC_LSB +: DISC_W] == $past(count[DISC_LSB +: DISC_W]) + 4'h1)
    else $error("disconnect field missed an event");

  a_false_field_inc: assert property ( // [R5]
    i_clk_en && width_sel && i_events.false_error && !rd_cnt
      && count[FALSE_LSB +: FALSE_W] != 4'hf
    |=> count[FALSE_LSB +: FALSE_W]
        == $past(count[FALSE_LSB +: FALSE_W]) + 4'h1)
    else $error("false error field missed an event");

  a_narrow_field_inc: assert property ( // [R6]
    i_clk_en && width_sel && i_events.rx_error && !rd_cnt
      && count[NARROW_LSB +: NARROW_W] != 8'hff
    |=> count[NARROW_LSB +: NARROW_W]
        == $past(count[NARROW_LSB +: NARROW_W]) + 8'h01)
    else $error("narrow field missed a receive error");

  a_status_reserved: assert property ( // [R7]
    i_clk_en && rd_stat
    |=> o_wb_ack && o_wb_dat[RSVD_HI_MSB:RSVD_HI_LSB] == 7'h00
        && o_wb_dat[6] == 1'b0)
    else $error("reserved status bits read nonzero");

  a_flag_sticky: assert property ( // [R8] [R10] [R11] [R12] [R13]
    i_clk_en && flags != FLAGS_RST && !rd_stat
    |=> (flags & $past(flags)) == $past(flags))
    else $error("latched flag dropped without a status read");

  a_code_flag_set: assert property ( // [R9]
    i_clk_en && i_events.code_violation
    |=> flags[1] ##1 (o_wb_dat[CODE_VIOL_BIT] || !$past(rd_stat) || !$past(i_clk_en)))
    else $error("code violation flag not latched");

  a_flag_read_clear: assert property ( // [R9]
    i_clk_en && rd_stat && flag_events == '0 |=> flags == FLAGS_RST)
    else $error("status read did not clear the flags");

  a_fast_link_live: assert property ( // [R14]
    i_clk_en && rd_stat
    |=> o_wb_dat[FAST_LINK_BIT] == $past(i_events.fast_link))
    else $error("fast link bit not live");

  a_slow_link_live: assert property ( // [R15]
    i_clk_en && rd_stat
    |=> o_wb_dat[SLOW_LINK_BIT] == $past(i_events.slow_link))
    else $error("slow link bit not live");

  a_clear_keeps_event: assert property ( // [R16]
    i_clk_en && rd_cnt && !width_sel && i_events.rx_error
    |=> count == 16'h0001)
    else $error("event lost under a clearing read");

  a_wide_saturates: assert property ( // [R17]
    i_clk_en && !width_sel && !rd_cnt && count == 16'hffff
    |=> count == 16'hffff)
    else $error("wide counter wrapped");

  a_ack_single: assert property (
    i_clk_en && o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");

  // A stalled clock enable keeps every register where it stands
  a_enable_freeze: assert property (
    !i_clk_en
    |=> $stable(count) && $stable(flags) && $stable(width_sel)
        && $stable(o_wb_ack) && $stable(o_wb_dat))
    else $error("state moved while the clock enable was low");

  a_ack_follows_req: assert property (
    i_clk_en && access |=> o_wb_ack)
    else $error("request taken without an ack");

  a_ack_needs_req: assert property (
    i_clk_en && !access |=> !o_wb_ack)
    else $error("ack raised without a request");

  // Read data checks; ack and data leave the same edge
  a_cnt_read_data: assert property ( // [R1] [R2] [R6]
    i_clk_en && rd_cnt |=> o_wb_dat == {16'h0000, $past(count)})
    else $error("counter read data differs from the count");

  a_write_reads_zero: assert property ( // [R1]
    i_clk_en && access && i_wb.we |=> o_wb_dat == RDATA_RST)
    else $error("write returned nonzero data");

  a_unmapped_zero: assert property (
    i_clk_en && access && !hit_cnt && !hit_stat |=> o_wb_dat == RDATA_RST)
    else $error("unmapped address returned nonzero data");

  a_upper_half_zero: assert property ( // [R7]
    o_wb_ack |-> o_wb_dat[DATA_W-1:REG_W] == 16'h0000)
    else $error("upper half of read data nonzero");

  // Counting per mode; a quiet cycle leaves the count alone
  a_wide_ignores_split: assert property ( // [R2]
    i_clk_en && !width_sel && !rd_cnt && !i_events.rx_error |=> $stable(count))
    else $error("wide count moved without a receive error");

  a_split_idle_hold: assert property ( // [R4] [R5] [R6]
    i_clk_en && width_sel && !rd_cnt && !i_events.rx_error
      && !i_events.disconnect && !i_events.false_error
    |=> $stable(count))
    else $error("split fields moved without an event");

  a_split_clear_keeps: assert property ( // [R16]
    i_clk_en && rd_cnt && width_sel
    |=> count == {3'h0, $past(i_events.disconnect), 3'h0,
                  $past(i_events.false_error), 7'h00, $past(i_events.rx_error)})
    else $error("split event lost under a clearing read");

  // Saturation per split field; the other fields may still move
  a_disc_saturates: assert property ( // [R17]
    i_clk_en && width_sel && !rd_cnt && count[DISC_LSB +: DISC_W] == 4'hf
    |=> count[DISC_LSB +: DISC_W] == 4'hf)
    else $error("disconnect field wrapped");

  a_false_saturates: assert property ( // [R17]
    i_clk_en && width_sel && !rd_cnt && count[FALSE_LSB +: FALSE_W] == 4'hf
    |=> count[FALSE_LSB +: FALSE_W] == 4'hf)
    else $error("false error field wrapped");

  a_narrow_saturates: assert property ( // [R17]
    i_clk_en && width_sel && !rd_cnt && count[NARROW_LSB +: NARROW_W] == 8'hff
    |=> count[NARROW_LSB +: NARROW_W] == 8'hff)
    else $error("narrow field wrapped");

  // Flags: every event sets its own flag, and a read after it shows the bit
  a_flag_set_all: assert property ( // [R8] [R9] [R10] [R11] [R12] [R13]
    i_clk_en && flag_events != '0
    |=> (flags & $past(flag_events)) == $past(flag_events))
    else $error("event did not latch its flag");

  a_frame_flag_read: assert property ( // [R8]
    i_clk_en && i_events.missing_delim ##1 i_clk_en && rd_stat
    |=> o_wb_dat[MISSING_DELIM_BIT])
    else $error("missing delimiter not reported in its status bit");

  a_drop_flag_read: assert property ( // [R10]
    i_clk_en && i_events.link_drop ##1 i_clk_en && rd_stat
    |=> o_wb_dat[LINK_DROP_BIT])
    else $error("link drop not reported in its status bit");

  a_unlock_flag_read: assert property ( // [R11]
    i_clk_en && i_events.scrambler_unlock ##1 i_clk_en && rd_stat
    |=> o_wb_dat[UNLOCK_BIT])
    else $error("scrambler unlock not reported in its status bit");

  a_carrier_flag_read: assert property ( // [R12]
    i_clk_en && i_events.false_carrier ##1 i_clk_en && rd_stat
    |=> o_wb_dat[FALSE_CARRIER_BIT])
    else $error("false carrier not reported in its status bit");

  a_jam_flag_read: assert property ( // [R13]
    i_clk_en && i_events.jam_forced ##1 i_clk_en && rd_stat
    |=> o_wb_dat[JAM_BIT])
    else $error("forced jam not reported in its status bit");

  // Main scenarios worth seeing
  c_split_mode_count: cover property (
    width_sel && i_clk_en && i_events.disconnect ##1 rd_cnt);
  c_clear_with_event: cover property (
    i_clk_en && rd_cnt && i_events.rx_error);
  c_wide_saturated: cover property (count == 16'hffff);
  c_flag_read_set: cover property (
    i_clk_en && rd_stat && flags[0] ##1 o_wb_dat[MISSING_DELIM_BIT]);
  c_enable_stall: cover property (
    !i_clk_en && i_events.rx_error);

endmodule

// [testbench/tb_pecsr_regs.sv]
// Self-checking bench for the error counter and extra status register bank.
// Assumes a one-cycle Wishbone ack; clock-enable stalls only while the bus is idle.
`timescale 1ns/1ps

module tb_pecsr_regs;
  import pecsr_pkg::*;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_clk_en = 1'b1;
  pecsr_wb_req_t i_wb = '0;
  pecsr_events_t i_events = '0;
  logic o_wb_ack;
  logic [DATA_W-1:0] o_wb_dat;
  logic [10:0] ev_mask = 11'h000;
  logic [10:0] ev_force = 11'h000;
  int fails = 0;
  int total_checks = 0;
  int m_split, m_wide, m_nar, m_disc, m_fer, m_mode;
  logic [5:0] m_flags;
  logic [DATA_W-1:0] m_snap;

  pecsr_regs pecsr_regs_inst (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_wb(i_wb),
    .i_events(i_events),
    .o_wb_ack(o_wb_ack),
    .o_wb_dat(o_wb_dat)
  );

  always #5 i_mclk = ~i_mclk;

  // Random event traffic, forced bits for saturation runs
  always @(posedge i_mclk) begin
    i_events <= pecsr_events_t'(11'($urandom) & ev_mask | ev_force);
  end

  function automatic int sat(int v, logic e, int mx);
    return (e && v < mx) ? v + 1 : v;
  endfunction

  // Reference model; clear happens before the same-edge event so set wins
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      m_split = 0; m_wide = 0; m_nar = 0; m_disc = 0; m_fer = 0;
      m_flags = '0;
      m_snap = '0;
    end else if (i_clk_en) begin
      // Mode before this edge; a width write only counts from the next event
      m_mode = m_split;
      if (i_wb.cyc && i_wb.stb && !o_wb_ack) begin
        m_snap = '0;
        if (!i_wb.we && i_wb.adr == ERR_CNT_ADDR) begin
          m_snap[15:0] = m_split ? {4'(m_disc), 4'(m_fer), 8'(m_nar)} : 16'(m_wide);
          m_wide = 0; m_nar = 0; m_disc = 0; m_fer = 0;
        end
        if (!i_wb.we && i_wb.adr == STATUS_ADDR) begin
          m_snap[8:0] = {m_flags[5:4], 1'b0, m_flags[3:0], i_events.fast_link,
                         i_events.slow_link};
          m_flags = '0;
        end
        if (i_wb.we && i_wb.adr == ERR_CNT_ADDR && i_wb.sel[0]) m_split = int'(i_wb.dat[0]);
      end
      m_flags = m_flags | i_events[7:2];
      if (m_mode != 0) begin
        m_nar = sat(m_nar, i_events.rx_error, 255);
        m_disc = sat(m_disc, i_events.disconnect, 15);
        m_fer = sat(m_fer, i_events.false_error, 15);
      end else begin
        m_wide = sat(m_wide, i_events.rx_error, 65535);
      end
    end
  end

  task automatic tally_and_finish();
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One classic cycle; read data or zero compared with the model at ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                    input logic [31:0] dat);
    // No cycle limit here: a missing ack is left to the watchdog
    i_wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    do begin
      @(posedge i_mclk);
    end while (o_wb_ack !== 1'b1);
    total_checks++;
    if (o_wb_dat !== m_snap) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, o_wb_dat, m_snap);
    end
    i_wb <= '0;
    @(posedge i_mclk);
  endtask

  // Quiet the events, clear the counter, then pick the width
  task automatic set_mode(input logic split);
    ev_mask = 11'h000;
    ev_force = 11'h000;
    repeat (3) @(posedge i_mclk);
    wb(1'b0, ERR_CNT_ADDR, 4'h0, 32'h0);
    wb(1'b1, ERR_CNT_ADDR, 4'h1, {$urandom} & 32'hffff_fffe | 32'(split));
    wb(1'b0, ERR_CNT_ADDR, 4'h0, 32'h0);
  endtask

  task automatic traffic(input logic [10:0] mask);
    ev_mask = mask;
    repeat (25) begin
      repeat ($urandom % 20) @(posedge i_mclk);
      wb(1'b0, ERR_CNT_ADDR, 4'h0, 32'h0);
      wb(1'b0, STATUS_ADDR, 4'h0, 32'h0);
    end
  endtask

  initial begin
    repeat (80000) @(posedge i_mclk);
    fails++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(54));
    repeat (5) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    wb(1'b0, ERR_CNT_ADDR, 4'h0, 32'h0);
    wb(1'b0, STATUS_ADDR, 4'h0, 32'h0);
    traffic(11'h4ff);
    // Ignored writes: lane 0 off, status, unmapped read
    wb(1'b1, ERR_CNT_ADDR, 4'he, 32'hffff_ffff);
    wb(1'b1, STATUS_ADDR, 4'hf, 32'hffff_ffff);
    wb(1'b0, 8'h58, 4'h0, 32'h0);
    set_mode(1'b1);
    traffic(11'h7ff);
    // Saturation of the split fields
    ev_force = 11'h700;
    repeat (300) @(posedge i_mclk);
    wb(1'b0, ERR_CNT_ADDR, 4'h0, 32'h0);
    // Random clock-enable stalls with the bus idle; every field must freeze
    ev_force = 11'h000;
    repeat (60) begin
      @(posedge i_mclk);
      i_clk_en <= 1'($urandom % 3 != 0);
    end
    @(posedge i_mclk);
    i_clk_en <= 1'b1;
    @(posedge i_mclk);
    wb(1'b0, ERR_CNT_ADDR, 4'h0, 32'h0);
    wb(1'b0, STATUS_ADDR, 4'h0, 32'h0);
    // Mid-run reset: back to wide mode, so split-only events must not count
    ev_mask = 11'h000;
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    ev_force = 11'h300;
    repeat (20) @(posedge i_mclk);
    ev_force = 11'h000;
    repeat (3) @(posedge i_mclk);
    wb(1'b0, ERR_CNT_ADDR, 4'h0, 32'h0);
    wb(1'b0, STATUS_ADDR, 4'h0, 32'h0);
    set_mode(1'b0);
    // Full 16-bit run; 65600 cycles, still under the 80000-cycle watchdog
    ev_force = 11'h400;
    repeat (65600) @(posedge i_mclk);
    wb(1'b0, ERR_CNT_ADDR, 4'h0, 32'h0);
    ev_force = 11'h000;
    repeat (3) @(posedge i_mclk);
    wb(1'b0, ERR_CNT_ADDR, 4'h0, 32'h0);
    tally_and_finish();
  end
endmodule
